// *** hdl/reg_access_bank.sv ***
// register bank showing each bit access kind behind two management ports
`timescale 1ns/1ns
`include "reg_access_map.svh"
module reg_access_bank (
    // clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    // spi management access, request held until ack
    input wire logic I_SPI_REQ,
    input wire logic I_SPI_WR,
    input wire logic [`RA_ADDR_W-1:0] I_SPI_ADDR,
    input wire logic [`RA_DATA_W-1:0] I_SPI_WDATA,
    output logic O_SPI_ACK,
    // i2c management access, request held until ack
    input wire logic I_I2C_REQ,
    input wire logic I_I2C_WR,
    input wire logic [`RA_ADDR_W-1:0] I_I2C_ADDR,
    input wire logic [`RA_DATA_W-1:0] I_I2C_WDATA,
    output logic O_I2C_ACK,
    // read answer shared by both ports
    output logic [`RA_DATA_W-1:0] O_RDATA,
    output logic O_RVALID,
    output reg_access_pkg::mgmt_port_t O_RSRC,
    // hardware status and events
    input wire logic [`RA_DATA_W-1:0] I_STATUS,
    input wire logic [`RA_DATA_W-1:0] I_EVENT,
    input wire logic I_COUNT_INC,
    input wire logic [`RA_DATA_W-1:0] I_LATCH_COND,
    // command and control outputs, with the command done input
    output logic [`RA_DATA_W-1:0] O_CTRL,
    output logic [`RA_DATA_W-1:0] O_KEY,
    output logic O_KEY_STB,
    output logic [`RA_DATA_W-1:0] O_CMD_START,
    input wire logic [`RA_DATA_W-1:0] I_CMD_DONE
);
    typedef struct packed {
        reg_access_pkg::reg_byte_t ctrl;
        reg_access_pkg::reg_byte_t event_flags;
        reg_access_pkg::reg_byte_t count;
        reg_access_pkg::reg_byte_t key;
        logic key_stb;
        reg_access_pkg::reg_byte_t cmd;
        reg_access_pkg::reg_byte_t latch;
        reg_access_pkg::reg_byte_t rdata;
        logic rvalid;
        reg_access_pkg::mgmt_port_t rsrc;
    } state_t;
    state_t st_reg, st_next;

    logic acc;
    logic wr;
    logic [`RA_ADDR_W-1:0] addr;
    logic [`RA_DATA_W-1:0] wdata;
    reg_access_pkg::mgmt_port_t src;
    logic rd;
    logic wr_event;
    logic rd_count;
    logic rd_latch;

    // one access per cycle keeps each read side effect single
    reg_access_arb u_arb (
        .i_clk(I_CLK_SYS),
        .i_rst_n(I_RST_N),
        .i_spi_req(I_SPI_REQ),
        .i_spi_wr(I_SPI_WR),
        .i_spi_addr(I_SPI_ADDR),
        .i_spi_wdata(I_SPI_WDATA),
        .o_spi_ack(O_SPI_ACK),
        .i_i2c_req(I_I2C_REQ),
        .i_i2c_wr(I_I2C_WR),
        .i_i2c_addr(I_I2C_ADDR),
        .i_i2c_wdata(I_I2C_WDATA),
        .o_i2c_ack(O_I2C_ACK),
        .o_acc(acc),
        .o_wr(wr),
        .o_addr(addr),
        .o_wdata(wdata),
        .o_src(src)
    );

    function automatic logic hit(input logic [`RA_ADDR_W-1:0] a,
                                 input logic [`RA_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // latch view: low bits latch low, high bits latch high
    function automatic reg_access_pkg::reg_byte_t latch_fold(
        input reg_access_pkg::reg_byte_t held,
        input reg_access_pkg::reg_byte_t cond);
        latch_fold = ((held & cond) & `RA_LL_MASK) | ((held | cond) & `RA_LH_MASK);
    endfunction : latch_fold

    // the counter sticks at its top value rather than wrapping back to small counts
    function automatic reg_access_pkg::reg_byte_t sat_step(
        input reg_access_pkg::reg_byte_t v);
        sat_step = (v == `RA_COUNT_MAX) ? v : v + 8'h01;
    endfunction : sat_step

    assign rd = acc && !wr;
    // decoded strobes, true only in the one cycle that an access is taken
    assign wr_event = acc && wr && hit(addr, `RA_OFS_EVENT);
    assign rd_count = rd && hit(addr, `RA_OFS_COUNT);
    assign rd_latch = rd && hit(addr, `RA_OFS_LATCH);

    always_comb begin
        st_next = st_reg;
        st_next.rvalid = 1'b0;
        st_next.key_stb = 1'b0;

        // latch capture runs every cycle; a read below reloads from the live condition
        st_next.latch = latch_fold(st_reg.latch, I_LATCH_COND);
        // sticky events; a new event beats a clear in the same cycle
        if (wr_event) begin
            st_next.event_flags = st_reg.event_flags & ~wdata;
        end
        st_next.event_flags = st_next.event_flags | I_EVENT;
        // self clearing command bits drop when the action reports done
        st_next.cmd = st_reg.cmd & ~I_CMD_DONE;

        if (acc && wr) begin
            case (addr)
                `RA_OFS_CTRL: begin
                    // the top bit is reserved and always stored as zero
                    st_next.ctrl = wdata & `RA_CTRL_MASK;
                end
                `RA_OFS_STAT: begin
                    // live status has no storage, so the write is dropped
                end
                `RA_OFS_EVENT: begin
                    // handled above so that a new event can win over the clear
                end
                `RA_OFS_COUNT: begin
                    // contents change only by counting or by a read
                end
                `RA_OFS_KEY: begin
                    st_next.key = wdata;
                    st_next.key_stb = 1'b1;
                end
                `RA_OFS_CMD: begin
                    st_next.cmd = st_next.cmd | wdata;
                end
                `RA_OFS_LATCH: begin
                    // latched status is read only
                end
                default: begin
                    // reserved address, nothing is stored
                end
            endcase
        end

        if (rd) begin
            // data and source stand until the next read answer
            st_next.rvalid = 1'b1;
            st_next.rsrc = src;
            case (addr)
                `RA_OFS_CTRL: begin
                    st_next.rdata = st_reg.ctrl;
                end
                `RA_OFS_STAT: begin
                    st_next.rdata = I_STATUS;
                end
                `RA_OFS_EVENT: begin
                    st_next.rdata = st_reg.event_flags;
                end
                `RA_OFS_COUNT: begin
                    st_next.rdata = st_reg.count;
                end
                `RA_OFS_KEY: begin
                    st_next.rdata = `RA_WO_READ;
                end
                `RA_OFS_CMD: begin
                    st_next.rdata = st_reg.cmd;
                end
                `RA_OFS_LATCH: begin
                    st_next.rdata = st_reg.latch;
                end
                default: begin
                    st_next.rdata = `RA_RSVD_READ;
                end
            endcase
        end

        // read side effects fire once, on the single accepted read cycle
        if (rd_count) begin
            // an increment in the read cycle is kept, not lost to the clear
            st_next.count = {7'h00, I_COUNT_INC};
        end else if (I_COUNT_INC) begin
            st_next.count = sat_step(st_reg.count);
        end
        if (rd_latch) begin
            st_next.latch = I_LATCH_COND;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            st_reg <= '{ctrl: `RA_CTRL_RESET, latch: `RA_LATCH_RESET,
                        rsrc: reg_access_pkg::PORT_IDLE, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // every output except the two port acks comes straight from a flip-flop
    assign O_RDATA = st_reg.rdata;
    assign O_RVALID = st_reg.rvalid;
    assign O_RSRC = st_reg.rsrc;
    assign O_CTRL = st_reg.ctrl;
    assign O_KEY = st_reg.key;
    assign O_KEY_STB = st_reg.key_stb;
    assign O_CMD_START = st_reg.cmd;
endmodule : reg_access_bank

// *** hdl/reg_access_map.svh ***
// offsets, field layouts and reset values of the register bit access layer
`ifndef REG_ACCESS_MAP_SVH
`define REG_ACCESS_MAP_SVH
`define RA_ADDR_W 3
`define RA_DATA_W 8
`define RA_NUM_REGS 8
`define RA_OFS_CTRL 3'h0
`define RA_OFS_STAT 3'h1
`define RA_OFS_EVENT 3'h2
`define RA_OFS_COUNT 3'h3
`define RA_OFS_KEY 3'h4
`define RA_OFS_CMD 3'h5
`define RA_OFS_LATCH 3'h6
`define RA_OFS_RSVD 3'h7
`define RA_CTRL_RESET 8'h00
`define RA_CTRL_MASK 8'h7F
`define RA_LL_MASK 8'h0F
`define RA_LH_MASK 8'hF0
`define RA_WO_READ 8'h00
`define RA_RSVD_READ 8'h00
`define RA_LATCH_RESET 8'h0F
`define RA_COUNT_MAX 8'hFF
`endif

// *** hdl/reg_access_pkg.sv ***
// types shared by the register bit access layer
package reg_access_pkg;
    typedef enum logic [1:0] {
        PORT_IDLE = 2'b00,
        PORT_SPI = 2'b01,
        PORT_I2C = 2'b10
    } mgmt_port_t;
    typedef logic [7:0] reg_byte_t;
endpackage : reg_access_pkg

// *** hdl/reg_access_arb.sv ***
// arbiter joining the two management ports into one register access
`timescale 1ns/1ns
`include "reg_access_map.svh"
module reg_access_arb (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // spi side
    input wire logic i_spi_req,
    input wire logic i_spi_wr,
    input wire logic [`RA_ADDR_W-1:0] i_spi_addr,
    input wire logic [`RA_DATA_W-1:0] i_spi_wdata,
    output logic o_spi_ack,
    // i2c side
    input wire logic i_i2c_req,
    input wire logic i_i2c_wr,
    input wire logic [`RA_ADDR_W-1:0] i_i2c_addr,
    input wire logic [`RA_DATA_W-1:0] i_i2c_wdata,
    output logic o_i2c_ack,
    // merged access, one cycle pulse
    output logic o_acc,
    output logic o_wr,
    output logic [`RA_ADDR_W-1:0] o_addr,
    output logic [`RA_DATA_W-1:0] o_wdata,
    output reg_access_pkg::mgmt_port_t o_src
);
    typedef struct packed {
        logic last_i2c;
    } state_t;
    state_t st_reg, st_next;
    logic pick_i2c;

    // alternate on conflict so neither port starves
    always_comb begin
        st_next = st_reg;
        pick_i2c = i_i2c_req && (!i_spi_req || !st_reg.last_i2c);
        if (i_spi_req || i_i2c_req) begin
            st_next.last_i2c = pick_i2c;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_acc = i_spi_req || i_i2c_req;
    assign o_wr = pick_i2c ? i_i2c_wr : i_spi_wr;
    assign o_addr = pick_i2c ? i_i2c_addr : i_spi_addr;
    assign o_wdata = pick_i2c ? i_i2c_wdata : i_spi_wdata;
    assign o_src = !o_acc ? reg_access_pkg::PORT_IDLE :
                   (pick_i2c ? reg_access_pkg::PORT_I2C : reg_access_pkg::PORT_SPI);
    assign o_spi_ack = i_spi_req && !pick_i2c;
    assign o_i2c_ack = pick_i2c;
endmodule : reg_access_arb

// *** bench/reg_access_bank_sva.sv ***
// port assertions for the register bit access layer
`timescale 1ns/1ns
`include "reg_access_map.svh"
module reg_access_bank_sva (
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    input wire logic I_SPI_WR,
    input wire logic [2:0] I_SPI_ADDR,
    input wire logic [7:0] I_SPI_WDATA,
    input wire logic O_SPI_ACK,
    input wire logic I_I2C_WR,
    input wire logic [2:0] I_I2C_ADDR,
    input wire logic O_I2C_ACK,
    input wire logic [7:0] O_RDATA,
    input wire logic O_RVALID,
    input wire reg_access_pkg::mgmt_port_t O_RSRC,
    input wire logic [7:0] I_STATUS,
    input wire logic [7:0] O_CTRL,
    input wire logic O_KEY_STB,
    input wire logic [7:0] O_CMD_START,
    input wire logic [7:0] I_CMD_DONE
);
    default clocking @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_RST_N);
    logic s_rd, i_rd, s_wr, i_wr, wr_key, wr_cmd;
    assign s_rd = O_SPI_ACK && !I_SPI_WR;
    assign i_rd = O_I2C_ACK && !I_I2C_WR;
    assign s_wr = O_SPI_ACK && I_SPI_WR;
    assign i_wr = O_I2C_ACK && I_I2C_WR;
    assign wr_key = (s_wr && I_SPI_ADDR == `RA_OFS_KEY) || (i_wr && I_I2C_ADDR == `RA_OFS_KEY);
    assign wr_cmd = (s_wr && I_SPI_ADDR == `RA_OFS_CMD) || (i_wr && I_I2C_ADDR == `RA_OFS_CMD);
    property p_one;
        !(O_SPI_ACK && O_I2C_ACK);
    endproperty
    a_one: assert property (p_one) else $error("two accepts");
    property p_ans;
        s_rd |=> O_RVALID && O_RSRC == reg_access_pkg::PORT_SPI;
    endproperty
    a_ans: assert property (p_ans) else $error("no read answer");
    property p_ans_i2c;
        i_rd |=> O_RVALID && O_RSRC == reg_access_pkg::PORT_I2C;
    endproperty
    a_ans_i2c: assert property (p_ans_i2c) else $error("no i2c read answer");
    property p_rv;
        O_RVALID |-> $past(s_rd || i_rd);
    endproperty
    a_rv: assert property (p_rv) else $error("stray read answer");
    property p_stat;
        s_rd && I_SPI_ADDR == `RA_OFS_STAT |=> O_RDATA == $past(I_STATUS);
    endproperty
    a_stat: assert property (p_stat) else $error("status read wrong");
    property p_ctrl;
        s_wr && I_SPI_ADDR == `RA_OFS_CTRL |=> O_CTRL == ($past(I_SPI_WDATA) & `RA_CTRL_MASK);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control not stored");
    property p_key;
        O_KEY_STB |-> $past(wr_key);
    endproperty
    a_key: assert property (p_key) else $error("key strobe without write");
    property p_done;
        I_CMD_DONE != 8'h00 && !wr_cmd |=> (O_CMD_START & $past(I_CMD_DONE)) == 8'h00;
    endproperty
    a_done: assert property (p_done) else $error("command bit not cleared");
    property p_rise;
        (O_CMD_START & ~$past(O_CMD_START)) != 8'h00 |-> $past(wr_cmd);
    endproperty
    a_rise: assert property (p_rise) else $error("command bit set unasked");
endmodule : reg_access_bank_sva
bind reg_access_bank reg_access_bank_sva reg_access_bank_sva_i (.*);

// *** bench/host_port_model.sv ***
// host side of one management port
`timescale 1ns/1ns
module host_port_model (
    input wire logic i_clk,
    input wire logic i_ack,
    input wire logic [7:0] i_rdata,
    output logic o_req,
    output logic o_wr,
    output logic [2:0] o_addr,
    output logic [7:0] o_wdata
);
    initial {o_req, o_wr, o_addr, o_wdata} = 13'h0000;
    // held until ack is sampled; released lines show the inverse, not a stale value
    task automatic xfer(input logic w, input logic [2:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge i_clk);
        #1;
        {o_req, o_wr, o_addr, o_wdata} = {1'h1, w, a, d};
        do @(posedge i_clk); while (i_ack !== 1'h1);
        #1;
        q = i_rdata;
        {o_req, o_wr, o_addr, o_wdata} = {1'h0, ~w, ~a, ~d};
    endtask : xfer
endmodule : host_port_model

// *** bench/reg_access_bank_bench.sv ***
// self-checking bench of the register bit access layer
`timescale 1ns/1ns
`include "reg_access_map.svh"
module reg_access_bank_bench;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic s_req, s_wr, s_ack, i_req, i_wr, i_ack, inc, rv, kstb;
    logic [1:0] rs;
    logic [2:0] s_adr, i_adr;
    logic [7:0] s_wd, i_wd, rd, stat, ev, cond, ctrl, key, cmd, done, q, r;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    initial begin
        forever #20 clk = ~clk;
    end
    reg_access_bank reg_access_bank_i (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_SPI_REQ(s_req),
        .I_SPI_WR(s_wr), .I_SPI_ADDR(s_adr), .I_SPI_WDATA(s_wd), .O_SPI_ACK(s_ack),
        .I_I2C_REQ(i_req), .I_I2C_WR(i_wr), .I_I2C_ADDR(i_adr), .I_I2C_WDATA(i_wd),
        .O_I2C_ACK(i_ack), .O_RDATA(rd), .O_RVALID(rv), .O_RSRC(rs), .I_STATUS(stat),
        .I_EVENT(ev), .I_COUNT_INC(inc), .I_LATCH_COND(cond), .O_CTRL(ctrl), .O_KEY(key),
        .O_KEY_STB(kstb), .O_CMD_START(cmd), .I_CMD_DONE(done));
    host_port_model hs (.i_clk(clk), .i_ack(s_ack), .i_rdata(rd), .o_req(s_req),
        .o_wr(s_wr), .o_addr(s_adr), .o_wdata(s_wd));
    host_port_model hi (.i_clk(clk), .i_ack(i_ack), .i_rdata(rd), .o_req(i_req),
        .o_wr(i_wr), .o_addr(i_adr), .o_wdata(i_wd));
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_total++;
            close_out();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out();
        if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    task automatic e1();
        @(posedge clk);
        #1;
    endtask : e1
    task automatic t_rw();
        hs.xfer(1'h1, `RA_OFS_CTRL, 8'h6B, q);
        hi.xfer(1'h0, `RA_OFS_CTRL, 8'h00, q);
        check(q, 8'h6B);
        check(ctrl, 8'h6B);
        check({5'h00, rv, rs}, {5'h00, 1'h1, reg_access_pkg::PORT_I2C});
        hi.xfer(1'h1, `RA_OFS_RSVD, 8'h00, q);
        hi.xfer(1'h0, `RA_OFS_RSVD, 8'h00, q);
        check(q, `RA_RSVD_READ);
        stat = 8'hA5;
        hi.xfer(1'h1, `RA_OFS_STAT, 8'h00, q);
        hs.xfer(1'h0, `RA_OFS_STAT, 8'h00, q);
        check(q, 8'hA5);
        check({5'h00, rv, rs}, {5'h00, 1'h1, reg_access_pkg::PORT_SPI});
    endtask : t_rw
    task automatic t_rc();
        repeat (5) begin
            e1();
            inc = 1'h1;
            e1();
            inc = 1'h0;
        end
        hs.xfer(1'h1, `RA_OFS_COUNT, 8'h00, q);
        hs.xfer(1'h0, `RA_OFS_COUNT, 8'h00, q);
        check(q, 8'h05);
        repeat (3) begin
            e1();
            inc = 1'h1;
            e1();
            inc = 1'h0;
        end
        fork
            hs.xfer(1'h0, `RA_OFS_COUNT, 8'h00, q);
            hi.xfer(1'h0, `RA_OFS_COUNT, 8'h00, r);
        join
        check(q ^ r, 8'h03);
        check(q & r, 8'h00);
    endtask : t_rc
    task automatic t_ev();
        e1();
        ev = 8'hFF;
        e1();
        ev = 8'h00;
        hs.xfer(1'h1, `RA_OFS_EVENT, 8'h0F, q);
        hi.xfer(1'h0, `RA_OFS_EVENT, 8'h00, q);
        check(q, 8'hF0);
        hi.xfer(1'h1, `RA_OFS_KEY, 8'h3C, q);
        check(key, 8'h3C);
        check({7'h00, kstb}, 8'h01);
        hi.xfer(1'h0, `RA_OFS_KEY, 8'h00, q);
        check(q, `RA_WO_READ);
    endtask : t_ev
    task automatic t_sc();
        hs.xfer(1'h1, `RA_OFS_CMD, 8'h05, q);
        hi.xfer(1'h1, `RA_OFS_CMD, 8'h00, q);
        hs.xfer(1'h0, `RA_OFS_CMD, 8'h00, q);
        check(q, 8'h05);
        done = 8'h01;
        e1();
        done = 8'h00;
        check(cmd, 8'h04);
    endtask : t_sc
    task automatic t_rst();
        e1();
        rst_n = 1'h0;
        e1();
        check(cmd, 8'h00);
        check(key, 8'h00);
        rst_n = 1'h1;
        hi.xfer(1'h0, `RA_OFS_CTRL, 8'h00, q);
        check(q, `RA_CTRL_RESET);
        hs.xfer(1'h0, `RA_OFS_LATCH, 8'h00, q);
        check(q, `RA_LATCH_RESET);
    endtask : t_rst
    task automatic t_lat();
        cond = 8'h1E;
        e1();
        cond = 8'h0F;
        hs.xfer(1'h0, `RA_OFS_LATCH, 8'h00, q);
        check(q, 8'h1E);
        hi.xfer(1'h0, `RA_OFS_LATCH, 8'h00, q);
        check(q, 8'h0F);
    endtask : t_lat
    initial begin
        {inc, stat, ev, cond, done} = {1'h0, 8'h00, 8'h00, 8'h0F, 8'h00};
        repeat (10) @(posedge clk);
        #1;
        rst_n = 1'h1;
        t_rw();
        t_rc();
        t_ev();
        t_sc();
        t_rst();
        t_lat();
        close_out();
    end
endmodule : reg_access_bank_bench
